// >>> hw/uart_rx_line_status_regs.svh
// Register offsets, field positions, reset values and timing counts
// for the receive line-status block. Included by the design file only.
`ifndef UART_RX_LINE_STATUS_REGS_SVH
`define UART_RX_LINE_STATUS_REGS_SVH

// =============================================================
// Register indices (byte address is four times the index)
`define URLS_IDX_RECEIVE_HOLDING   8'h00
`define URLS_IDX_IRQ_ENABLE_MASK   8'h01
`define URLS_IDX_IRQ_STATUS        8'h02
`define URLS_IDX_RX_ERROR_MASK     8'h03
`define URLS_IDX_RX_LINE_STATUS    8'h04
`define URLS_IDX_STALE_LIMIT       8'h10
`define URLS_IDX_SECOND_MODE       8'h11

// =============================================================
// Field positions
`define URLS_BIT_CTS_LIVE          7
`define URLS_BIT_NOISE             5
`define URLS_BIT_BREAK             4
`define URLS_BIT_STOP_FAULT        3
`define URLS_BIT_PARITY            2
`define URLS_BIT_OVERFLOW          1
`define URLS_BIT_STALE             0
`define URLS_BIT_LINE_ERROR_SUM    0
`define URLS_BIT_LINE_ERROR_IEN    0
`define URLS_BIT_PARITY_ON         0
`define URLS_BIT_PARITY_EVEN       1
`define URLS_BIT_NINE_BIT          6

// =============================================================
// Reset values
`define URLS_RST_MASK              8'h00
`define URLS_RST_STALE_LIMIT       8'h00
`define URLS_RST_SECOND_MODE       8'h00
`define URLS_MASK_USED             8'h3f

// =============================================================
// Timing: clock period and one serial bit time, both in ns
`define URLS_CLK_NS                4
`define URLS_BIT_NS                64
`define URLS_BIT_CYCLES            (`URLS_BIT_NS / `URLS_CLK_NS)
`define URLS_FIFO_DEPTH            128

`endif

// >>> hw/urls_pkg.sv
// Types shared by the receive line-status block.
// Constants live in the _regs header; this package holds types only.
package urls_pkg;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } urls_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } urls_apb_rsp_t;

    // One receive queue entry: the character and its own flags
    typedef struct packed {
        logic       noise;
        logic       brk;
        logic       frame;
        logic       parity;
        logic [7:0] data;
    } urls_entry_t;

    typedef enum logic [2:0] {
        URLS_IDLE,
        URLS_START,
        URLS_DATA,
        URLS_PARBIT,
        URLS_STOP,
        URLS_LINE_LOW
    } urls_rx_state_t;

endpackage

// >>> hw/uart_rx_line_status.sv
// Receive line-status logic: serial receiver, 128-entry receive queue
// with per-character flags, line status and summary interrupt bit.
// Assumes an APB master on ref_clk and RX/CTS levels synchronous to it.
`timescale 1ns/100ps
`include "uart_rx_line_status_regs.svh"
`default_nettype none

// How it works
// [RL1] Enabled error flags drive summary status bit 0
// [RL2] Mask bits 5..0: noise,break,frame,parity,overrun,timeout
// [RL3] Mask bits 7,6 unused; mask resets zero
// [RL4] Line status shows oldest queued character flags
// [RL5] Status read keeps character flags; holding read clears
// [RL6] Bit 7 mirrors clear-to-send input level
// [RL7] Bit 7 follows input after reset; bit6 zero
// [RL8] Noise during reception tags that character
// [RL9] Long low line queues zero break character
// [RL10] Missing stop bit sets framing flag
// [RL11] Parity mismatch sets parity flag
// [RL12] Nine-bit mode reports ninth bit instead
// [RL13] Full queue: drop new, set overrun
// [RL14] Overrun clears on status read or room
// [RL15] Stale timeout flag after programmed period
// [RL16] Holding read or receive restarts timeout, clears flag
// [RL17] Zero timeout setting disables the flag
// [RL18] Summary set while enabled flag; clears on read
// [RL19] Holding read returns and pops oldest entry
// [RL20] IRQ from summary only with enable bit0
// [RL21] Flags stored with entry; OR of masked flags
module uart_rx_line_status
    import urls_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    reset,
    input  wire urls_pkg::urls_apb_req_t apbReq,
    output urls_pkg::urls_apb_rsp_t      apbRsp,
    input  wire logic                    rxIn,
    input  wire logic                    ctsIn,
    output logic                         irqN
);
    import urls_pkg::*;

    localparam int BITC  = `URLS_BIT_CYCLES;
    localparam int MID   = BITC / 2;
    localparam int DEPTH = `URLS_FIFO_DEPTH;

    // =============================================================
    // Helpers
    function automatic logic maj3(input logic [2:0] s);
        maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    function automatic logic isIdx(input logic [7:0] a, input logic [7:0] idx);
        isIdx = (a == {idx[5:0], 2'b00}) && (idx[7:6] == 2'b00);
    endfunction

    // =============================================================
    // Register storage
    logic [7:0]       errMask_r;
    logic             lineErrIrqEn_r;
    logic [7:0]       staleLimit_r;
    logic [7:0]       secondMode_r;
    logic             lineErrSum_r;
    logic             overflow_r;
    logic             stale_r;
    logic [31:0]      rdData_r;
    logic             rdPop_r;

    // Receive queue
    urls_entry_t      queue_r [DEPTH];
    logic [6:0]       wrPtr_r;
    logic [6:0]       rdPtr_r;
    logic [7:0]       count_r;

    // Receiver
    urls_rx_state_t   rxState_r;
    logic [3:0]       phase_r;
    logic [2:0]       smp_r;
    logic [2:0]       bitIdx_r;
    logic [7:0]       shift_r;
    logic             parBit_r;
    logic             noise_r;
    logic             rxDone_r;
    urls_entry_t      rxChar_r;

    // Stale timer
    logic [3:0]       tick_r;
    logic [8:0]       staleCnt_r;

    // =============================================================
    // APB decode
    logic        setup;
    logic        access;
    logic        wrAcc;
    logic        rdAcc;
    logic        mapped;
    logic        full;
    logic        empty;
    logic        push;
    logic        pop;
    logic        lsrRead;
    logic        isrRead;
    logic        sampleBit;
    logic        lastPhase;
    logic        parityUsed;
    urls_entry_t head;
    logic [7:0]  lineStatus;
    logic [5:0]  liveFlags;
    logic [31:0] rdMux;

    assign setup   = apbReq.psel && !apbReq.penable;
    assign access  = apbReq.psel && apbReq.penable;
    assign wrAcc   = access && apbReq.pwrite;
    assign rdAcc   = access && !apbReq.pwrite;
    assign mapped  = isIdx(apbReq.paddr, `URLS_IDX_RECEIVE_HOLDING)
                   || isIdx(apbReq.paddr, `URLS_IDX_IRQ_ENABLE_MASK)
                   || isIdx(apbReq.paddr, `URLS_IDX_IRQ_STATUS)
                   || isIdx(apbReq.paddr, `URLS_IDX_RX_ERROR_MASK)
                   || isIdx(apbReq.paddr, `URLS_IDX_RX_LINE_STATUS)
                   || isIdx(apbReq.paddr, `URLS_IDX_STALE_LIMIT)
                   || isIdx(apbReq.paddr, `URLS_IDX_SECOND_MODE);

    // Zero wait states: read data is captured in the setup cycle
    // One driver for the whole response, as the port is a variable
    assign apbRsp = '{prdata: rdData_r, pready: 1'b1, pslverr: access && !mapped};

    assign full    = (count_r == 8'(DEPTH));
    assign empty   = (count_r == 8'h00);
    assign head    = empty ? '0 : queue_r[rdPtr_r];
    assign push    = rxDone_r && !full;
    assign pop     = rdAcc && rdPop_r && isIdx(apbReq.paddr, `URLS_IDX_RECEIVE_HOLDING); // RL19
    assign lsrRead = rdAcc && isIdx(apbReq.paddr, `URLS_IDX_RX_LINE_STATUS);
    assign isrRead = rdAcc && isIdx(apbReq.paddr, `URLS_IDX_IRQ_STATUS);

    // Line status always reflects the head entry, not a read snapshot
    assign liveFlags = {head.noise, head.brk, head.frame, head.parity, overflow_r, stale_r}; // RL4
    assign lineStatus = {ctsIn, 1'b0, liveFlags}; // RL6 RL7

    always_comb
    begin
        rdMux = 32'h0000_0000;
        if (isIdx(apbReq.paddr, `URLS_IDX_RECEIVE_HOLDING))
            rdMux[7:0] = head.data; // RL19
        else if (isIdx(apbReq.paddr, `URLS_IDX_IRQ_ENABLE_MASK))
            rdMux[`URLS_BIT_LINE_ERROR_IEN] = lineErrIrqEn_r;
        else if (isIdx(apbReq.paddr, `URLS_IDX_IRQ_STATUS))
            rdMux[`URLS_BIT_LINE_ERROR_SUM] = lineErrSum_r;
        else if (isIdx(apbReq.paddr, `URLS_IDX_RX_ERROR_MASK))
            rdMux[7:0] = errMask_r;
        else if (isIdx(apbReq.paddr, `URLS_IDX_RX_LINE_STATUS))
            rdMux[7:0] = lineStatus;
        else if (isIdx(apbReq.paddr, `URLS_IDX_STALE_LIMIT))
            rdMux[7:0] = staleLimit_r;
        else if (isIdx(apbReq.paddr, `URLS_IDX_SECOND_MODE))
            rdMux[7:0] = secondMode_r;
    end

    // =============================================================
    // Read capture
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            rdData_r <= 32'h0000_0000;
            rdPop_r  <= 1'b0;
        end
        else if (setup && !apbReq.pwrite)
        begin
            rdData_r <= rdMux;
            // Pop only what was shown, so an empty read never eats a late arrival
            rdPop_r  <= !empty;
        end
    end

    // =============================================================
    // Software-written registers
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            errMask_r      <= `URLS_RST_MASK; // RL3
            lineErrIrqEn_r <= 1'b0;
            staleLimit_r   <= `URLS_RST_STALE_LIMIT;
            secondMode_r   <= `URLS_RST_SECOND_MODE;
        end
        else if (wrAcc)
        begin
            if (isIdx(apbReq.paddr, `URLS_IDX_RX_ERROR_MASK))
                errMask_r <= apbReq.pwdata[7:0] & `URLS_MASK_USED; // RL3
            if (isIdx(apbReq.paddr, `URLS_IDX_IRQ_ENABLE_MASK))
                lineErrIrqEn_r <= apbReq.pwdata[`URLS_BIT_LINE_ERROR_IEN];
            if (isIdx(apbReq.paddr, `URLS_IDX_STALE_LIMIT))
                staleLimit_r <= apbReq.pwdata[7:0];
            if (isIdx(apbReq.paddr, `URLS_IDX_SECOND_MODE))
                secondMode_r <= apbReq.pwdata[7:0];
        end
    end

    // =============================================================
    // Summary bit and interrupt pin
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            lineErrSum_r <= 1'b0;
        else if (|(liveFlags & errMask_r[5:0])) // RL1 RL2 RL21
            lineErrSum_r <= 1'b1; // RL18
        else if (isrRead)
            lineErrSum_r <= 1'b0; // RL18
    end

    assign irqN = !(lineErrSum_r && lineErrIrqEn_r); // RL20

    // =============================================================
    // Receive queue
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            wrPtr_r <= 7'h00;
            rdPtr_r <= 7'h00;
            count_r <= 8'h00;
        end
        else
        begin
            if (push)
                wrPtr_r <= wrPtr_r + 7'h01;
            if (pop)
                rdPtr_r <= rdPtr_r + 7'h01; // RL5 RL19
            if (push && !pop)
                count_r <= count_r + 8'h01;
            else if (pop && !push)
                count_r <= count_r - 8'h01;
        end
    end

    // Storage has no reset; entries are only read once written
    always_ff @(posedge ref_clk)
    begin
        if (push)
            queue_r[wrPtr_r] <= rxChar_r; // RL21
    end

    // Overflow: a new arrival wins over a clear in the same cycle
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            overflow_r <= 1'b0;
        else if (rxDone_r && full)
            overflow_r <= 1'b1; // RL13
        else if (lsrRead || !full)
            overflow_r <= 1'b0; // RL14
    end

    // =============================================================
    // Stale-data timer, counted in bit times
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            tick_r     <= 4'h0;
            staleCnt_r <= 9'h000;
            stale_r    <= 1'b0;
        end
        else
        begin
            tick_r <= (tick_r == 4'(BITC - 1)) ? 4'h0 : tick_r + 4'h1;
            if (push || pop)
            begin
                tick_r     <= 4'h0;
                staleCnt_r <= 9'h000; // RL16
                stale_r    <= 1'b0; // RL16
            end
            else if (staleLimit_r == 8'h00 || empty)
            begin
                staleCnt_r <= 9'h000;
                stale_r    <= 1'b0; // RL17
            end
            else
            begin
                if (tick_r == 4'(BITC - 1) && !staleCnt_r[8])
                    staleCnt_r <= staleCnt_r + 9'h001;
                if (staleCnt_r > {1'b0, staleLimit_r})
                    stale_r <= 1'b1; // RL15
            end
        end
    end

    // =============================================================
    // Serial receiver, three samples around mid-bit
    assign lastPhase  = (phase_r == 4'(BITC - 1));
    assign sampleBit  = maj3(smp_r);
    assign parityUsed = secondMode_r[`URLS_BIT_PARITY_ON] || secondMode_r[`URLS_BIT_NINE_BIT];

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            rxState_r <= URLS_IDLE;
            phase_r   <= 4'h0;
            smp_r     <= 3'b000;
            bitIdx_r  <= 3'h0;
            shift_r   <= 8'h00;
            parBit_r  <= 1'b0;
            noise_r   <= 1'b0;
            rxDone_r  <= 1'b0;
            rxChar_r  <= '0;
        end
        else
        begin
            rxDone_r <= 1'b0;
            if (rxState_r != URLS_IDLE && rxState_r != URLS_LINE_LOW)
            begin
                phase_r <= lastPhase ? 4'h0 : phase_r + 4'h1;
                if (phase_r == 4'(MID - 1))
                    smp_r[0] <= rxIn;
                if (phase_r == 4'(MID))
                    smp_r[1] <= rxIn;
                if (phase_r == 4'(MID + 1))
                    smp_r[2] <= rxIn;
                // Disagreeing samples within one bit count as line noise
                if (lastPhase && (smp_r != 3'b000) && (smp_r != 3'b111))
                    noise_r <= 1'b1; // RL8
            end
            unique case (rxState_r)
                URLS_IDLE:
                    if (!rxIn)
                    begin
                        rxState_r <= URLS_START;
                        phase_r   <= 4'h0;
                        noise_r   <= 1'b0;
                        parBit_r  <= 1'b0;
                    end
                URLS_START:
                    if (lastPhase)
                    begin
                        rxState_r <= sampleBit ? URLS_IDLE : URLS_DATA;
                        bitIdx_r  <= 3'h0;
                    end
                URLS_DATA:
                    if (lastPhase)
                    begin
                        shift_r  <= {sampleBit, shift_r[7:1]};
                        bitIdx_r <= bitIdx_r + 3'h1;
                        if (bitIdx_r == 3'h7)
                            rxState_r <= parityUsed ? URLS_PARBIT : URLS_STOP;
                    end
                URLS_PARBIT:
                    if (lastPhase)
                    begin
                        parBit_r  <= sampleBit;
                        rxState_r <= URLS_STOP;
                    end
                URLS_STOP:
                    if (lastPhase)
                    begin
                        rxDone_r       <= 1'b1;
                        rxChar_r.data  <= shift_r;
                        rxChar_r.noise <= noise_r || ((smp_r != 3'b000) && (smp_r != 3'b111));
                        // Low through the whole frame is a break, not a framing fault
                        rxChar_r.brk   <= !sampleBit && shift_r == 8'h00 && !parBit_r; // RL9
                        rxChar_r.frame <= !sampleBit && !(shift_r == 8'h00 && !parBit_r); // RL10
                        if (secondMode_r[`URLS_BIT_NINE_BIT])
                            rxChar_r.parity <= parBit_r; // RL12
                        else if (secondMode_r[`URLS_BIT_PARITY_ON])
                            rxChar_r.parity <= (^{shift_r, parBit_r})
                                ^ !secondMode_r[`URLS_BIT_PARITY_EVEN]; // RL11
                        else
                            rxChar_r.parity <= 1'b0;
                        rxState_r <= sampleBit ? URLS_IDLE : URLS_LINE_LOW;
                    end
                URLS_LINE_LOW:
                    if (rxIn)
                        rxState_r <= URLS_IDLE;
            endcase
        end
    end

    // =============================================================
    // Checks
    AST_MASK_RSV: assert property (@(posedge ref_clk) disable iff (reset) // RL3
        errMask_r[7:6] == 2'b00)
        else $error("mask bits 7 and 6 not zero");

    AST_SUM_SET: assert property (@(posedge ref_clk) disable iff (reset) // RL1
        |(liveFlags & errMask_r[5:0]) |=> lineErrSum_r)
        else $error("enabled flag did not set summary bit");

    AST_IRQ_GATE: assert property (@(posedge ref_clk) disable iff (reset) // RL20
        (lineErrSum_r && lineErrIrqEn_r) |-> !irqN)
        else $error("irq pin not asserted with summary and enable");

    AST_IRQ_QUIET: assert property (@(posedge ref_clk) disable iff (reset) // RL20
        (!lineErrIrqEn_r || !lineErrSum_r) |-> irqN)
        else $error("irq pin asserted without summary and enable");

    AST_CTS_READ: assert property (@(posedge ref_clk) disable iff (reset) // RL6
        (setup && !apbReq.pwrite && isIdx(apbReq.paddr, `URLS_IDX_RX_LINE_STATUS))
        |=> rdData_r[7] == $past(ctsIn) && rdData_r[6] == 1'b0)
        else $error("status bit 7 does not mirror cts");

    AST_OVR_SET: assert property (@(posedge ref_clk) disable iff (reset) // RL13
        (rxDone_r && full) |=> overflow_r && count_r == 8'(DEPTH) || $past(pop))
        else $error("overrun not flagged or queue changed");

    AST_STALE_OFF: assert property (@(posedge ref_clk) disable iff (reset) // RL17
        (staleLimit_r == 8'h00) [*2] |-> !stale_r)
        else $error("stale flag set with zero limit");

    AST_STALE_CLR: assert property (@(posedge ref_clk) disable iff (reset) // RL16
        (push || pop) |=> !stale_r && staleCnt_r == 9'h000)
        else $error("stale timer not restarted");

    AST_POP_CNT: assert property (@(posedge ref_clk) disable iff (reset) // RL19
        (pop && !push) |=> count_r == $past(count_r) - 8'h01)
        else $error("holding read did not remove an entry");

    AST_BREAK_ZERO: assert property (@(posedge ref_clk) disable iff (reset) // RL9
        (rxDone_r && rxChar_r.brk) |-> rxChar_r.data == 8'h00 && !rxChar_r.frame)
        else $error("break character not all zero");

    AST_LSR_HOLD: assert property (@(posedge ref_clk) disable iff (reset) // RL5
        (lsrRead && !push && !pop && !empty) |=> $stable(liveFlags[5:2]))
        else $error("status read changed character flags");

endmodule

`default_nettype wire

// >>> verif/urls_line_partner.sv
// Behavioural line transceiver that drives the serial receive input.
// Assumes 16 clock cycles per bit and a line that idles high.
`timescale 1ns/100ps
`default_nettype none
module urls_line_partner
(
    input  wire logic ref_clk,
    output logic      rxOut
);
    initial rxOut = 1'b1;

    // =====================================
    // One bit time; optional one-cycle glitch mid-bit
    task automatic bitOut(input logic v, input logic g);
        for (int i = 0; i < 16; i++)
        begin
            rxOut <= (g && i == 8) ? ~v : v;
            @(posedge ref_clk);
        end
    endtask

    // =====================================
    // Start, data LSB first, optional parity, stop, then one idle bit
    task automatic send(input logic [7:0] d, input logic hasPar, input logic p,
                        input logic stp, input int gl);
        bitOut(1'b0, 1'b0);
        for (int i = 0; i < 8; i++)
            bitOut(d[i], gl == i);
        if (hasPar)
            bitOut(p, 1'b0);
        bitOut(stp, 1'b0);
        // Idle high lets the receiver rearm after a low stop bit
        bitOut(1'b1, 1'b0);
    endtask
endmodule
`default_nettype wire

// >>> verif/uart_rx_line_status_bench.sv
// Self-checking bench for the receive line-status block.
// Assumes urls_pkg and the line partner model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module uart_rx_line_status_bench;
    import urls_pkg::*;
    localparam logic [7:0] A_RHR = 8'h00, A_IEN = 8'h04, A_ISR = 8'h08;
    localparam logic [7:0] A_MSK = 8'h0c, A_LSR = 8'h10, A_STL = 8'h40;
    localparam logic [7:0] A_MOD = 8'h44;
    logic          ref_clk, reset, ctsIn, rxLine, irqN, lastErr;
    urls_apb_req_t apbReq;
    urls_apb_rsp_t apbRsp;
    int            failures, n_checks;
    logic [31:0]   rd;

    uart_rx_line_status uart_rx_line_status_inst (.ref_clk(ref_clk), .reset(reset),
        .apbReq(apbReq), .apbRsp(apbRsp), .rxIn(rxLine), .ctsIn(ctsIn), .irqN(irqN));
    urls_line_partner urls_line_partner_inst (.ref_clk(ref_clk), .rxOut(rxLine));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // =====================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        lastErr = apbRsp.pslverr;
        apbReq <= '0;
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    task automatic send(input logic [7:0] d, input logic hp, input logic p, input logic s);
        urls_line_partner_inst.send(d, hp, p, s, -1);
    endtask

    // =====================================
    // Scenarios
    task automatic t_reset();
        rdc("lsr cts", A_LSR, 32'h80);
        rdc("mask", A_MSK, 32'h0);
        @(posedge ref_clk) ctsIn <= 1'b0;
        rdc("lsr cts", A_LSR, 32'h0);
        apb(1'b1, A_MSK, 32'hff);
        rdc("mask", A_MSK, 32'h3f);
        rdc("unmapped", 8'h20, 32'h0);
        chk("slverr", lastErr, 1'b1);
        apb(1'b1, A_MSK, 32'h0);
        $display("t_reset done");
    endtask

    task automatic t_flags();
        logic [7:0] dat[4] = '{8'h5a, 8'h33, 8'h00, 8'ha5};
        logic [7:0] flg[4] = '{8'h20, 8'h08, 8'h10, 8'h00};
        urls_line_partner_inst.send(8'h5a, 1'b0, 1'b0, 1'b1, 3);
        send(8'h33, 1'b0, 1'b0, 1'b0);
        send(8'h00, 1'b0, 1'b0, 1'b0);
        send(8'ha5, 1'b0, 1'b0, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            rdc("lsr", A_LSR, flg[i]);
            rdc("lsr again", A_LSR, flg[i]);
            rdc("rhr", A_RHR, dat[i]);
        end
        $display("t_flags done");
    endtask

    task automatic t_parity();
        logic [7:0] md[5] = '{8'h01, 8'h01, 8'h03, 8'h41, 8'h41};
        logic [7:0] d[5] = '{8'h01, 8'h03, 8'h01, 8'h00, 8'h00};
        logic       p[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        logic       e;
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, A_MOD, md[i]);
            e = md[i][6] ? p[i] : ~(^d[i] ^ p[i] ^ md[i][1]);
            send(d[i], 1'b1, p[i], 1'b1);
            rdc("parity", A_LSR, {29'h0, e, 2'b00});
            rdc("rhr", A_RHR, d[i]);
        end
        apb(1'b1, A_MOD, 32'h0);
        $display("t_parity done");
    endtask

    task automatic t_summary();
        apb(1'b1, A_MOD, 32'h01);
        send(8'h01, 1'b1, 1'b1, 1'b1);
        apb(1'b1, A_IEN, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, A_MSK, 32'h1 << i);
            apb(1'b0, A_ISR, 32'h0);
            rdc("summary", A_ISR, i == 2);
            @(negedge ref_clk);
            chk("irq", irqN, i != 2);
        end
        apb(1'b1, A_MSK, 32'h04);
        apb(1'b1, A_IEN, 32'h0);
        rdc("summary", A_ISR, 32'h1);
        @(negedge ref_clk);
        chk("irq off", irqN, 1'b1);
        apb(1'b1, A_MSK, 32'h0);
        apb(1'b0, A_ISR, 32'h0);
        rdc("summary clr", A_ISR, 32'h0);
        rdc("rhr", A_RHR, 32'h01);
        apb(1'b1, A_MOD, 32'h0);
        $display("t_summary done");
    endtask

    task automatic t_stale();
        apb(1'b1, A_STL, 32'h2);
        send(8'h11, 1'b0, 1'b0, 1'b1);
        rdc("stale early", A_LSR, 32'h0);
        repeat (64) @(posedge ref_clk);
        rdc("stale", A_LSR, 32'h1);
        send(8'h22, 1'b0, 1'b0, 1'b1);
        rdc("stale push", A_LSR, 32'h0);
        repeat (64) @(posedge ref_clk);
        rdc("stale", A_LSR, 32'h1);
        rdc("rhr", A_RHR, 32'h11);
        rdc("stale pop", A_LSR, 32'h0);
        apb(1'b1, A_STL, 32'h0);
        repeat (128) @(posedge ref_clk);
        rdc("stale off", A_LSR, 32'h0);
        rdc("rhr", A_RHR, 32'h22);
        $display("t_stale done");
    endtask

    task automatic t_overrun();
        // 129 frames: the last one finds the queue full
        for (int i = 0; i < 129; i++)
            send(i[7:0], 1'b0, 1'b0, 1'b1);
        rdc("overrun", A_LSR, 32'h02);
        rdc("overrun rd", A_LSR, 32'h0);
        rdc("kept", A_RHR, 32'h0);
        apb(1'b1, A_MSK, 32'h02);
        send(8'hc0, 1'b0, 1'b0, 1'b1);
        send(8'hc1, 1'b0, 1'b0, 1'b1);
        rdc("overrun sum", A_ISR, 32'h1);
        rdc("rhr", A_RHR, 32'h01);
        rdc("overrun pop", A_LSR, 32'h0);
        apb(1'b1, A_MSK, 32'h0);
        for (int i = 0; i < 126; i++)
            apb(1'b0, A_RHR, 32'h0);
        rdc("last kept", A_RHR, 32'hc0);
        $display("t_overrun done");
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        failures = 0;
        n_checks = 0;
        reset = 1'b1;
        ctsIn = 1'b1;
        apbReq = '0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_flags();
        t_parity();
        t_summary();
        t_stale();
        t_overrun();
        end_sim();
    end

    // Whole run needs about 26k cycles
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        failures++;
        end_sim();
    end
endmodule
`default_nettype wire
